/* pkg/iad_pkg.sv */
// Constants, register map and types shared by the I/O allocation and drive prohibit block.
package iad_pkg;
  // Byte offsets on the AHB-Lite register bus.
  localparam logic [7:0] ADDR_IN_SEL_BASE  = 8'h00;  // Input selections 1 to 10, one word each.
  localparam logic [7:0] ADDR_OUT_SEL_BASE = 8'h28;  // Output selections 1 to 4.
  localparam logic [7:0] ADDR_PROHIBIT_SEL = 8'h38;  // Prohibit selection.
  localparam logic [7:0] ADDR_STOP_METHOD  = 8'h3C;  // Stop method.
  localparam logic [7:0] ADDR_STOP_TORQUE  = 8'h40;  // Immediate stop torque.
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h44;  // Sticky events, write one to clear.
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h48;  // Interrupt mask.
  localparam logic [7:0] ADDR_STATUS       = 8'h4C;  // Live limit and stop state.
  localparam logic [7:0] ADDR_DECIMAL      = 8'h50;  // Decimal view of a selected parameter.
  localparam logic [7:0] ADDR_DEC_SEL      = 8'h54;  // Word index shown in decimal.
  localparam int N_IN  = 10;
  localparam int N_OUT = 4;
  localparam int N_FUNC = 16;
  // Reset values.
  localparam logic [31:0] RST_IN_SEL_1 = 32'h0082_8282;
  localparam logic [31:0] RST_IN_SEL_2 = 32'h0081_8181;
  localparam logic [31:0] RST_OUT_SEL_1 = 32'h0003_0303;
  localparam logic [31:0] RST_OUT_SEL_2 = 32'h0002_0202;
  localparam logic [31:0] RST_OUT_SEL_3 = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_SEL_4 = 32'h0005_0504;
  localparam logic [1:0]  RST_PROHIBIT  = 2'h1;
  // Input function codes used here, with the contact bit.
  localparam logic [6:0] IFN_FWD_LIMIT = 7'h01;
  localparam logic [6:0] IFN_REV_LIMIT = 7'h02;
  localparam int         IN_NC_BIT     = 7;
  // Output function codes.
  localparam logic [7:0] OFN_OFF = 8'h00;
  localparam logic [7:0] OFN_RDY = 8'h02;
  localparam logic [7:0] OFN_BRK = 8'h03;
  localparam logic [7:0] OFN_INP = 8'h04;
  localparam logic [7:0] OFN_ROT = 8'h05;
  localparam logic [7:0] OFN_TLC = 8'h06;
  localparam logic [7:0] OFN_ZSP = 8'h07;
  localparam logic [7:0] OFN_VCM = 8'h08;
  localparam logic [7:0] OFN_WA  = 8'h09;
  localparam logic [7:0] OFN_WB  = 8'h0A;
  localparam logic [7:0] OFN_PCM = 8'h0B;
  localparam logic [7:0] OFN_INB = 8'h0C;
  localparam logic [7:0] OFN_ALA = 8'h0E;
  localparam logic [7:0] OFN_VCS = 8'h0F;
  // Prohibit selections and stop methods.
  localparam logic [1:0] PROH_STOP   = 2'h0;
  localparam logic [1:0] PROH_IGNORE = 2'h1;
  localparam logic [1:0] PROH_ALARM  = 2'h2;
  localparam logic [1:0] STOP_DYN    = 2'h0;
  localparam logic [1:0] STOP_COAST  = 2'h1;
  localparam logic [1:0] STOP_IMM    = 2'h2;
  // Interrupt bits.
  localparam int IRQ_FWD   = 0;
  localparam int IRQ_REV   = 1;
  localparam int IRQ_ALARM = 2;
  localparam int IRQ_W     = 3;
  localparam int DEC_W     = 40;  // Ten BCD digits.
  typedef enum logic [1:0] {ST_RUN, ST_DECEL, ST_HELD} iad_stop_type;
endpackage

/* logic/iad_top.sv */
// Output allocation, drive prohibit logic and AHB-Lite register file.
`timescale 1ns/100ps
`default_nettype none
module iad_top #(
  parameter int N_TERM = 10  // Number of input terminals.
) (
  input  wire logic              i_sys_clk,     // 125 MHz clock.
  input  wire logic              i_arst_n,      // Asynchronous reset, active low.
  input  wire logic              hsel,          // Slave select.
  input  wire logic [31:0]       haddr,         // Byte address.
  input  wire logic [1:0]        htrans,        // Transfer type.
  input  wire logic              hwrite,        // Write when high.
  input  wire logic [2:0]        hsize,         // Transfer size.
  input  wire logic [31:0]       hwdata,        // Write data.
  input  wire logic              hready,        // Bus ready in.
  output logic [31:0]            hrdata,        // Read data.
  output logic                   hreadyout,     // Slave ready.
  output logic                   hresp,         // Always OKAY.
  input  wire logic [N_TERM-1:0] i_term_short,  // Terminal shorted to common return, from pins.
  input  wire logic              i_speed_mode,  // High in speed control, low in position control.
  input  wire logic [15:0]       i_status_fn,   // Internal status functions indexed by output code.
  input  wire logic              i_motor_stopped, // Motor has come to rest.
  output logic [3:0]             o_out_short,   // High shorts output terminal to common return.
  output logic                   o_fwd_block,   // Forward motion inhibited.
  output logic                   o_rev_block,   // Reverse motion inhibited.
  output logic                   o_dyn_brake,   // Dynamic brake engaged.
  output logic                   o_zero_torque, // Zero torque in the prohibited direction.
  output logic                   o_servo_lock,  // Servo lock after immediate stop.
  output logic                   o_clear_err,   // Clear error counter.
  output logic                   o_hold_err,    // Hold error counter.
  output logic                   o_torque_lim_en, // Torque limit active.
  output logic [15:0]            o_torque_lim,  // Torque limit value.
  output logic                   o_alarm,       // Drive prohibit input error alarm.
  output logic                   o_irq          // Level interrupt.
);
  // Whole module state as one packed struct.
  typedef struct packed {
    logic [iad_pkg::N_IN-1:0][31:0]  in_sel;     // Input selections.
    logic [iad_pkg::N_OUT-1:0][31:0] out_sel;    // Output selections.
    logic [1:0]                      prohibit;   // Prohibit selection.
    logic [1:0]                      stop_m;     // Stop method.
    logic [15:0]                     stop_tq;    // Immediate stop torque.
    logic [iad_pkg::IRQ_W-1:0]       irq_st;     // Sticky events.
    logic [iad_pkg::IRQ_W-1:0]       irq_mask;   // Mask.
    logic [3:0]                      dec_sel;    // Word shown in decimal.
    logic [N_TERM-1:0]               s1;         // Synchroniser first stage.
    logic [N_TERM-1:0]               s2;         // Second stage.
    logic [N_TERM-1:0]               s3;         // Third stage.
    logic [N_TERM-1:0]               pin;        // Accepted terminal level.
    logic                            fwd_open_q; // Previous forward open.
    logic                            rev_open_q; // Previous reverse open.
    iad_pkg::iad_stop_type           st;         // Stop sequence state.
    logic                            ph_act;     // Data phase pending.
    logic                            ph_wr;      // Pending is write.
    logic [7:0]                      ph_addr;    // Pending address.
    logic [31:0]                     rdata;      // Read data.
    logic                            ready;      // Bus ready, low for the one read wait state.
    logic [3:0]                      out_short;  // Output terminals.
    logic                            fwd_block;  // Forward inhibit.
    logic                            rev_block;  // Reverse inhibit.
    logic                            dyn_brake;  // Dynamic brake.
    logic                            zero_tq;    // Zero torque.
    logic                            servo_lock; // Servo lock.
    logic                            clear_err;  // Clear counter.
    logic                            hold_err;   // Hold counter.
    logic                            tlim_en;    // Torque limit on.
    logic                            alarm;      // Alarm.
    logic                            irq;        // Interrupt.
  } iad_state_type;

  iad_state_type cur;   // Registered state.
  iad_state_type next_s; // Next state.

  // Converts a binary word to ten BCD digits by shift and add three.
  function automatic logic [iad_pkg::DEC_W-1:0] to_bcd(input logic [31:0] v);
    logic [iad_pkg::DEC_W-1:0] b;
    b = '0;
    for (int i = 31; i >= 0; i--)
    begin
      for (int d = 0; d < 10; d++)
      begin
        if (b[d*4 +: 4] > 4'd4)
        begin
          b[d*4 +: 4] = b[d*4 +: 4] + 4'd3;
        end
      end
      b = {b[iad_pkg::DEC_W-2:0], v[i]};
    end
    return b;
  endfunction

  // Picks this mode's byte of a selection word.
  function automatic logic [7:0] mode_code(input logic [31:0] w, input logic spd);
    return spd ? w[15:8] : w[7:0];
  endfunction

  // Level of a limit function: true when its terminal is active, honouring contact logic.
  function automatic logic limit_active(input logic [iad_pkg::N_IN-1:0][31:0] sel, input logic spd,
                                        input logic [N_TERM-1:0] pin, input logic [6:0] fn);
    logic a;
    logic [7:0] c;
    a = 1'b0;
    for (int t = 0; t < iad_pkg::N_IN; t++)
    begin
      c = mode_code(sel[t], spd);
      if (c[6:0] == fn && t < N_TERM)
      begin
        a = c[iad_pkg::IN_NC_BIT] ? pin[t] : !pin[t];
      end
    end
    return a;
  endfunction

  // Output function decode; unknown codes leave the terminal open.
  function automatic logic out_fn(input logic [7:0] c, input logic [15:0] f);
    logic r;
    unique case (c)
      iad_pkg::OFN_RDY, iad_pkg::OFN_BRK, iad_pkg::OFN_INP, iad_pkg::OFN_ROT,
      iad_pkg::OFN_TLC, iad_pkg::OFN_ZSP, iad_pkg::OFN_VCM,
      iad_pkg::OFN_WA, iad_pkg::OFN_WB, iad_pkg::OFN_PCM, iad_pkg::OFN_INB,
      iad_pkg::OFN_ALA, iad_pkg::OFN_VCS:
        r = f[c[3:0]];
      default:
        r = 1'b0;
    endcase
    return r;
  endfunction

  logic fwd_act;   // Forward limit terminal shows normal (shorted) state.
  logic rev_act;   // Reverse limit terminal shows normal state.
  logic fwd_open;  // Forward limit open while prohibit is enabled.
  logic rev_open;  // Reverse limit open while prohibit is enabled.
  logic [iad_pkg::IRQ_W-1:0] ev; // Events this cycle.
  logic [iad_pkg::IRQ_W-1:0] wclr; // Write-one-to-clear bits.
  logic [31:0] rd;  // Read mux.
  logic [31:0] dec_src; // Word shown in decimal.
  logic [7:0] a8;   // Low address byte.
  logic [iad_pkg::DEC_W-1:0] bcd; // Decimal digits of the selected word.

  // Next-state logic for terminals, prohibit, stop sequence, outputs and bus.
  always_comb
  begin
    next_s = cur;
    wclr = '0;
    rd = 32'h0000_0000;
    a8 = cur.ph_addr;
    // Three-stage terminal synchroniser; a change is taken when stages two and three agree.
    next_s.s1 = i_term_short;
    next_s.s2 = cur.s1;
    next_s.s3 = cur.s2;
    for (int t = 0; t < N_TERM; t++)
    begin
      if (cur.s2[t] == cur.s3[t])
      begin
        next_s.pin[t] = cur.s3[t];
      end
    end
    // NC limit functions: shorted terminal is normal; the default map keeps prohibit ignored.
    fwd_act = limit_active(cur.in_sel, i_speed_mode, cur.pin, iad_pkg::IFN_FWD_LIMIT);
    rev_act = limit_active(cur.in_sel, i_speed_mode, cur.pin, iad_pkg::IFN_REV_LIMIT);
    fwd_open = (cur.prohibit != iad_pkg::PROH_IGNORE) && !fwd_act;
    rev_open = (cur.prohibit != iad_pkg::PROH_IGNORE) && !rev_act;
    next_s.fwd_open_q = fwd_open;
    next_s.rev_open_q = rev_open;
    // Selection 0 blocks only the open direction.
    next_s.fwd_block = (cur.prohibit == iad_pkg::PROH_STOP) && fwd_open;
    next_s.rev_block = (cur.prohibit == iad_pkg::PROH_STOP) && rev_open;
    // Alarm: both open under 0, either open under 2; it stays until reset.
    if ((cur.prohibit == iad_pkg::PROH_STOP && fwd_open && rev_open) ||
        (cur.prohibit == iad_pkg::PROH_ALARM && (fwd_open || rev_open)))
    begin
      next_s.alarm = 1'b1;
    end
    // Stop sequence.
    unique case (cur.st)
      iad_pkg::ST_RUN:
        if (next_s.fwd_block || next_s.rev_block)
        begin
          next_s.st = iad_pkg::ST_DECEL;
        end
      iad_pkg::ST_DECEL:
        if (!(next_s.fwd_block || next_s.rev_block))
        begin
          next_s.st = iad_pkg::ST_RUN;
        end
        else if (i_motor_stopped)
        begin
          next_s.st = iad_pkg::ST_HELD;
        end
      iad_pkg::ST_HELD:
        if (!(next_s.fwd_block || next_s.rev_block))
        begin
          next_s.st = iad_pkg::ST_RUN;
        end
    endcase
    // Stop method actions.
    next_s.dyn_brake  = (next_s.st == iad_pkg::ST_DECEL) && cur.stop_m == iad_pkg::STOP_DYN;
    next_s.zero_tq    = (next_s.st != iad_pkg::ST_RUN) && cur.stop_m != iad_pkg::STOP_IMM;
    next_s.servo_lock = (next_s.st == iad_pkg::ST_HELD) && cur.stop_m == iad_pkg::STOP_IMM;
    next_s.hold_err   = (next_s.st != iad_pkg::ST_RUN) && cur.stop_m != iad_pkg::STOP_IMM;
    next_s.clear_err  = (next_s.st != cur.st) && cur.stop_m == iad_pkg::STOP_IMM
                        && (next_s.st != iad_pkg::ST_RUN);
    next_s.tlim_en    = (next_s.st == iad_pkg::ST_DECEL) && cur.stop_m == iad_pkg::STOP_IMM;
    // Output terminals, each decoded alone so one function may feed several.
    for (int o = 0; o < iad_pkg::N_OUT; o++)
    begin
      next_s.out_short[o] = out_fn(mode_code(cur.out_sel[o], i_speed_mode), i_status_fn);
    end
    // Read mux.
    dec_src = (cur.dec_sel < 4'(iad_pkg::N_IN)) ? cur.in_sel[cur.dec_sel]
            : cur.out_sel[2'(cur.dec_sel - 4'(iad_pkg::N_IN))];
    bcd = to_bcd(dec_src);
    for (int i = 0; i < iad_pkg::N_IN; i++)
    begin
      if (a8 == iad_pkg::ADDR_IN_SEL_BASE + 8'(i * 4))
      begin
        rd = cur.in_sel[i];
      end
    end
    for (int i = 0; i < iad_pkg::N_OUT; i++)
    begin
      if (a8 == iad_pkg::ADDR_OUT_SEL_BASE + 8'(i * 4))
      begin
        rd = cur.out_sel[i];
      end
    end
    unique case (a8)
      iad_pkg::ADDR_PROHIBIT_SEL: rd = {30'h0000_0000, cur.prohibit};
      iad_pkg::ADDR_STOP_METHOD:  rd = {30'h0000_0000, cur.stop_m};
      iad_pkg::ADDR_STOP_TORQUE:  rd = {16'h0000, cur.stop_tq};
      iad_pkg::ADDR_IRQ_STATUS:   rd = {29'h0000_0000, cur.irq_st};
      iad_pkg::ADDR_IRQ_MASK:     rd = {29'h0000_0000, cur.irq_mask};
      iad_pkg::ADDR_STATUS:       rd = {26'h0000_0000, cur.st == iad_pkg::ST_HELD, cur.alarm,
                                        rev_open, fwd_open, rev_act, fwd_act};
      iad_pkg::ADDR_DECIMAL:      rd = bcd[31:0];
      iad_pkg::ADDR_DEC_SEL:      rd = {28'h0000_0000, cur.dec_sel};
      default: ;
    endcase
    // Data phase: reads answer from the registered mux, writes update here.
    if (cur.ph_act)
    begin
      if (!cur.ph_wr)
      begin
        next_s.rdata = rd;
      end
      else
      begin
        // Undefined codes are stored but leave the output open; software keeps to the code set.
        for (int i = 0; i < iad_pkg::N_IN; i++)
        begin
          if (a8 == iad_pkg::ADDR_IN_SEL_BASE + 8'(i * 4))
          begin
            next_s.in_sel[i] = {16'h0000, hwdata[15:0]};
          end
        end
        for (int i = 0; i < iad_pkg::N_OUT; i++)
        begin
          if (a8 == iad_pkg::ADDR_OUT_SEL_BASE + 8'(i * 4))
          begin
            next_s.out_sel[i] = {16'h0000, hwdata[15:0]};
          end
        end
        unique case (a8)
          iad_pkg::ADDR_PROHIBIT_SEL: next_s.prohibit = hwdata[1:0];
          iad_pkg::ADDR_STOP_METHOD:  next_s.stop_m = hwdata[1:0];
          iad_pkg::ADDR_STOP_TORQUE:  next_s.stop_tq = hwdata[15:0];
          iad_pkg::ADDR_IRQ_STATUS:   wclr = hwdata[iad_pkg::IRQ_W-1:0];
          iad_pkg::ADDR_IRQ_MASK:     next_s.irq_mask = hwdata[iad_pkg::IRQ_W-1:0];
          iad_pkg::ADDR_DEC_SEL:      next_s.dec_sel = hwdata[3:0];
          default: ;
        endcase
      end
    end
    // Address phase capture.
    next_s.ph_act = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1])
    begin
      next_s.ph_wr = hwrite;
      next_s.ph_addr = haddr[7:0];
    end
    // A read takes one wait state, so the word registered from the pending address stands when the phase ends.
    next_s.ready = !(hsel && hready && htrans[1] && !hwrite);
    // Sticky events: a new event wins over a clear in the same cycle.
    ev = '0;
    ev[iad_pkg::IRQ_FWD] = fwd_open && !cur.fwd_open_q;
    ev[iad_pkg::IRQ_REV] = rev_open && !cur.rev_open_q;
    ev[iad_pkg::IRQ_ALARM] = next_s.alarm && !cur.alarm;
    next_s.irq_st = (cur.irq_st & ~wclr) | ev;
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);
  end

  // State register.
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cur <= '0;
      cur.in_sel[0] <= iad_pkg::RST_IN_SEL_1;
      cur.in_sel[1] <= iad_pkg::RST_IN_SEL_2;
      cur.out_sel[0] <= iad_pkg::RST_OUT_SEL_1;
      cur.out_sel[1] <= iad_pkg::RST_OUT_SEL_2;
      cur.out_sel[2] <= iad_pkg::RST_OUT_SEL_3;
      cur.out_sel[3] <= iad_pkg::RST_OUT_SEL_4;
      cur.prohibit <= iad_pkg::RST_PROHIBIT;
      cur.st <= iad_pkg::ST_RUN;
      cur.ready <= 1'b1;
    end
    else
    begin
      cur <= next_s;
    end
  end

  // Outputs straight from flip-flops; hresp is tied to OKAY.
  assign hrdata = cur.rdata;
  assign hreadyout = cur.ready;
  assign hresp = 1'b0;
  assign o_out_short = cur.out_short;
  assign o_fwd_block = cur.fwd_block;
  assign o_rev_block = cur.rev_block;
  assign o_dyn_brake = cur.dyn_brake;
  assign o_zero_torque = cur.zero_tq;
  assign o_servo_lock = cur.servo_lock;
  assign o_clear_err = cur.clear_err;
  assign o_hold_err = cur.hold_err;
  assign o_torque_lim_en = cur.tlim_en;
  assign o_torque_lim = cur.stop_tq;
  assign o_alarm = cur.alarm;
  assign o_irq = cur.irq;

  // Under selection 1 the limits never block.
  ignore_limits_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $past(cur.prohibit) == iad_pkg::PROH_IGNORE && $past(cur.prohibit, 2) == iad_pkg::PROH_IGNORE
    |-> !o_fwd_block && !o_rev_block)
    else $error("limit acted while ignored");
  // The torque limit is on only in immediate stop decel, judged on the method in force one cycle before.
  stop_torque_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_torque_lim_en |-> $past(cur.stop_m) == iad_pkg::STOP_IMM && cur.st == iad_pkg::ST_DECEL)
    else $error("torque limit outside immediate stop");
  // Any blocked direction means the stop sequence has left the running state.
  block_stops_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (o_fwd_block || o_rev_block) |-> cur.st != iad_pkg::ST_RUN)
    else $error("block without stop sequence");
  // Selection 0 with both limits open raises the alarm on the next edge.
  both_open_alarm_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cur.prohibit == iad_pkg::PROH_STOP && fwd_open && rev_open |=> o_alarm)
    else $error("both limits open without alarm");
  // Selection 2 with either limit open raises the alarm on the next edge.
  either_open_alarm_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cur.prohibit == iad_pkg::PROH_ALARM && (fwd_open || rev_open) |=> o_alarm)
    else $error("open limit without alarm");
  // An immediate stop that reaches rest while its direction is still blocked.
  sequence imm_rest_s;
    cur.st == iad_pkg::ST_DECEL && cur.stop_m == iad_pkg::STOP_IMM && i_motor_stopped
    && cur.prohibit == iad_pkg::PROH_STOP && (fwd_open || rev_open);
  endsequence
  // Servo lock comes on together with a single clear pulse for the error counter.
  sequence lock_pulse_s;
    o_servo_lock && o_clear_err ##1 !o_clear_err;
  endsequence
  // Resting after an immediate stop locks the servo and clears the counter once.
  imm_lock_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    imm_rest_s |=> lock_pulse_s)
    else $error("immediate stop did not lock");
  // Interrupt equals the masked status in the same cycle.
  irq_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_irq == |(cur.irq_st & cur.irq_mask))
    else $error("irq mismatch");
endmodule
`default_nettype wire

/* test/iad_limit_model.sv */
// Limit switch model that sits in front of the input terminals of the block.
`timescale 1ns/100ps
`default_nettype none
module iad_limit_model (
  input  wire logic  i_fwd_open,   // Forward switch tripped.
  input  wire logic  i_rev_open,   // Reverse switch tripped.
  output logic [9:0] o_term_short  // Terminal levels towards the block.
);
  // Normally closed switches are wired to terminals 0 and 1, so a tripped switch opens its loop.
  // The other terminals are unwired and read open, the level a floating opto input shows.
  assign o_term_short = {8'h00, ~i_fwd_open, ~i_rev_open};
endmodule
`default_nettype wire

/* test/iad_top_bench.sv */
// Self-checking bench for the output allocation and drive prohibit block.
`timescale 1ns/100ps
`default_nettype none
module iad_top_bench;
  logic        i_sys_clk;        // System clock.
  logic        i_arst_n;         // Reset, active low.
  logic        hsel;             // Bus select.
  logic [31:0] haddr;            // Bus address.
  logic [1:0]  htrans;           // Transfer type.
  logic        hwrite;           // Write strobe.
  logic [2:0]  hsize;            // Word size.
  logic [31:0] hwdata;           // Write data.
  logic [31:0] hrdata;           // Read data.
  logic        hreadyout;        // Slave ready, also bus ready.
  logic        hresp;            // Response.
  logic [9:0]  term_short;       // Terminal levels.
  logic        i_speed_mode;     // Control mode.
  logic [15:0] i_status_fn;      // Internal status functions.
  logic        i_motor_stopped;  // Motor at rest.
  logic        fwd_open;         // Forward switch tripped.
  logic        rev_open;         // Reverse switch tripped.
  logic [3:0]  out_short;        // Output terminals.
  logic        fwd_blk;          // Forward inhibit.
  logic        rev_blk;          // Reverse inhibit.
  logic        dyn_brake;        // Dynamic brake.
  logic        zero_torque;      // Coast.
  logic        servo_lock;       // Servo lock.
  logic        clear_err;        // Error counter clear pulse.
  logic        hold_err;         // Error counter hold.
  logic        tlim_en;          // Torque limit active.
  logic [15:0] tlim;             // Torque limit value.
  logic        alarm;            // Prohibit alarm.
  logic        irq;              // Interrupt.
  logic [31:0] q;                // Last read word.
  int          mismatches;       // Mismatch count.
  int          compares;         // Comparison count.

  iad_limit_model iad_limit_model_inst (.i_fwd_open(fwd_open), .i_rev_open(rev_open), .o_term_short(term_short));
  iad_top iad_top_inst (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .i_term_short(term_short), .i_speed_mode(i_speed_mode), .i_status_fn(i_status_fn),
    .i_motor_stopped(i_motor_stopped), .o_out_short(out_short), .o_fwd_block(fwd_blk), .o_rev_block(rev_blk),
    .o_dyn_brake(dyn_brake), .o_zero_torque(zero_torque), .o_servo_lock(servo_lock), .o_clear_err(clear_err),
    .o_hold_err(hold_err), .o_torque_lim_en(tlim_en), .o_torque_lim(tlim), .o_alarm(alarm), .o_irq(irq));

  // Free running clock of 8 ns.
  initial
  begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Waits a number of rising edges.
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // One single word transfer; the address phase is held until ready, then the data phase likewise.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk(hresp, 32'h0000_0000);
  endtask

  // Holds reset for twelve cycles, then lets one edge pass before any request.
  task automatic do_reset;
    i_arst_n <= 1'b0;
    fwd_open <= 1'b0;
    rev_open <= 1'b0;
    tick(12);
    i_arst_n <= 1'b1;
    tick(1);
  endtask

  // Reset values and the unmapped hole, then limits without effect in the default setting.
  task automatic t_defaults;
    bus(0, 32'h0000_0000, 0); chk(q, 32'h0082_8282);
    bus(0, 32'h0000_0004, 0); chk(q, 32'h0081_8181);
    bus(0, 32'h0000_0028, 0); chk(q, 32'h0003_0303);
    bus(0, 32'h0000_0034, 0); chk(q, 32'h0005_0504);
    bus(0, 32'h0000_0038, 0); chk(q, 32'h0000_0001);
    bus(0, 32'h0000_0060, 0); chk(q, 32'h0000_0000);
    fwd_open <= 1'b1;
    rev_open <= 1'b1;
    tick(8);
    chk({fwd_blk, rev_blk, alarm}, 32'h0000_0000);
    fwd_open <= 1'b0;
    rev_open <= 1'b0;
    tick(8);
  endtask

  // Same code on two outputs, an undefined code, mode bytes, and the decimal view.
  task automatic t_outputs;
    bus(1, 32'h0000_0028, 32'hFFFF_0508);
    bus(1, 32'h0000_002C, 32'h0000_0508);
    bus(1, 32'h0000_0030, 32'h0000_00FF);
    bus(1, 32'h0000_0034, 32'h0000_0000);
    bus(0, 32'h0000_0028, 0); chk(q, 32'h0000_0508);
    i_status_fn <= 16'hFFFF ^ 16'h0020;
    i_speed_mode <= 1'b0;
    tick(3); chk(out_short, 32'h0000_0003);
    i_speed_mode <= 1'b1;
    tick(3); chk(out_short, 32'h0000_0000);
    i_status_fn <= 16'h0020;
    tick(3); chk(out_short, 32'h0000_0003);
    bus(1, 32'h0000_0028, 32'h0000_0E0F);
    tick(3); chk(out_short[0], 32'h0000_0000);
    i_status_fn <= 16'h4000;
    tick(3); chk(out_short[0], 32'h0000_0001);
    bus(1, 32'h0000_0028, 32'h0000_0508);
    bus(1, 32'h0000_0054, 32'h0000_000A);
    bus(0, 32'h0000_0050, 0); chk(q, 32'h0000_1288);
  endtask

  // Selection 0 with an interrupt raised, masked, unmasked and cleared.
  task automatic t_prohibit_irq;
    bus(1, 32'h0000_0038, 32'h0000_0000);
    bus(1, 32'h0000_0048, 32'h0000_0000);
    bus(1, 32'h0000_0044, 32'h0000_0007);
    fwd_open <= 1'b1;
    tick(8);
    chk({fwd_blk, rev_blk, alarm, dyn_brake}, 32'h0000_0009);
    chk(irq, 32'h0000_0000);
    bus(0, 32'h0000_0044, 0); chk(q, 32'h0000_0001);
    bus(1, 32'h0000_0048, 32'h0000_0007);
    tick(2); chk(irq, 32'h0000_0001);
    fwd_open <= 1'b0;
    tick(8);
    bus(1, 32'h0000_0044, 32'h0000_0001);
    tick(2); chk(irq, 32'h0000_0000);
  endtask

  // Each stop method on an open reverse limit; the immediate stop limits torque.
  task automatic t_stop_methods;
    bus(1, 32'h0000_0040, 32'h0000_1234);
    for (int m = 0; m < 3; m++)
    begin
      bus(1, 32'h0000_003C, m);
      rev_open <= 1'b1;
      tick(8);
      chk({fwd_blk, rev_blk}, 32'h0000_0001);
      case (m)
        0: chk({dyn_brake, hold_err}, 32'h0000_0003);
        1: chk({zero_torque, hold_err}, 32'h0000_0003);
        default: chk({tlim_en, tlim}, 32'h0001_1234);
      endcase
      // Once at rest the immediate stop locks the servo and pulses the counter clear.
      if (m == 2)
      begin
        i_motor_stopped <= 1'b1;
        tick(2);
        chk({servo_lock, clear_err, tlim_en, hold_err}, 32'h0000_000C);
        i_motor_stopped <= 1'b0;
      end
      rev_open <= 1'b0;
      tick(8);
    end
  endtask

  // Both limits open under selection 0, one limit open under selection 2.
  task automatic t_alarms;
    fwd_open <= 1'b1;
    rev_open <= 1'b1;
    tick(8); chk(alarm, 32'h0000_0001);
    do_reset();
    tick(4);
    bus(1, 32'h0000_0038, 32'h0000_0002);
    tick(8); chk(alarm, 32'h0000_0000);
    rev_open <= 1'b1;
    tick(8); chk(alarm, 32'h0000_0001);
  endtask

  // Watchdog for a hung bus wait.
  initial
  begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    i_speed_mode = 1'b0;
    i_status_fn = 16'h0000;
    i_motor_stopped = 1'b0;
    mismatches = 0;
    compares = 0;
    i_arst_n = 1'b0;
    do_reset();
    t_defaults();
    t_outputs();
    t_prohibit_irq();
    t_stop_methods();
    t_alarms();
    report_and_stop();
  end
endmodule
`default_nettype wire
